// ---- bench/core_prescale_rti_timer_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module core_prescale_rti_timer_bench;
   logic        clk = 0, sys_rst = 1, ext_reset_n = 1, cpu_irq_mask = 0;
   logic        stop_mode = 0, stop_wake = 0, e;
   logic        psel, penable, pwrite, pready, pslverr, wait_mode;
   logic        irq_req, wait_exit, stabilising, guard_timeout;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, d;
   logic [7:0]  c, v;
   int          miscompares = 0, checks_done = 0, cyc = 0;
   integer      seed = 32'hB238;
   always #5 clk = ~clk;
   core_prescale_rti_timer #(.STAB_CYCLES(16)) u_core_prescale_rti_timer (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_reset_n(ext_reset_n), .cpu_irq_mask(cpu_irq_mask), .wait_mode(wait_mode),
      .stop_mode(stop_mode), .stop_wake(stop_wake), .irq_req(irq_req),
      .wait_exit(wait_exit), .stabilising(stabilising), .guard_timeout(guard_timeout));
   host_cpu_model u_host_cpu_model (
      .clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .wait_exit(wait_exit),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .wait_mode(wait_mode));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task rd(input logic [11:0] a);
      u_host_cpu_model.xfer(a, 1'b0, 32'h0, r, e);
   endtask : rd
   task wr(input logic [11:0] a, input logic [7:0] x);
      u_host_cpu_model.xfer(a, 1'b1, {24'h0, x}, r, e);
   endtask : wr
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // the longest wait is one periodic interval at the fastest tap
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         end_of_test;
      end
   end
   initial begin
      tick(5);
      sys_rst <= 0;
      while (stabilising !== 1'b0) @(posedge clk);
      rd(12'h020);
      check(r, 32'h03);
      rd(12'h024);
      c = r[7:0];
      for (int i = 0; i < 4; i++) begin
         rd(12'h024);
         check(r[7:0], 8'(c + 8'h01));
         c = r[7:0];
      end
      wr(12'h024, 8'hFF);
      check(e, 1'b0);
      rd(12'h024);
      check(r[7:0], 8'(c + 8'h02));
      rd(12'h02C);
      check(e, 1'b1);
      rd(12'h028);
      check(e, 1'b1);
      $display("count test done");
      for (int i = 0; i < 8; i++) begin
         d = $random(seed);
         v = {2'b11, d[5:4], 2'b00, i[1:0]};
         wr(12'h028, 8'h00);
         check(e, 1'b0);
         wr(12'h020, v);
         rd(12'h020);
         check(r[5:0], {26'h0, v[5:0]});
      end
      rd(12'h024);
      if (r[7:0] > 8'hF0) tick(80);
      wr(12'h020, 8'h00);
      wr(12'h020, 8'hC0);
      rd(12'h020);
      check(r[7], 1'b0);
      tick(1030);
      rd(12'h020);
      check(r[7], 1'b1);
      wr(12'h020, 8'hA0);
      tick(2);
      check(irq_req, 1'b1);
      cpu_irq_mask <= 1;
      tick(2);
      check(irq_req, 1'b0);
      cpu_irq_mask <= 0;
      tick(2);
      check(irq_req, 1'b1);
      u_host_cpu_model.enter_wait;
      tick(2);
      check(wait_exit, 1'b1);
      tick(2);
      check(wait_mode, 1'b0);
      wr(12'h020, 8'h00);
      tick(2);
      check(irq_req, 1'b0);
      $display("overflow test done");
      tick(16400);
      rd(12'h020);
      check(r[6], 1'b1);
      check(guard_timeout, 1'b0);
      wr(12'h020, 8'h50);
      tick(2);
      check(irq_req, 1'b1);
      wr(12'h020, 8'h00);
      stop_mode <= 1;
      tick(3);
      rd(12'h024);
      check(r, 32'h0);
      stop_mode <= 0;
      stop_wake <= 1;
      tick(1);
      stop_wake <= 0;
      tick(2);
      check(stabilising, 1'b1);
      while (stabilising !== 1'b0) @(posedge clk);
      rd(12'h024);
      check(r[7:0] < 8'h04, 1'b1);
      ext_reset_n <= 0;
      tick(4);
      rd(12'h024);
      check(r, 32'h0);
      stop_mode <= 1;
      tick(4);
      check(stabilising, 1'b1);
      stop_mode <= 0;
      ext_reset_n <= 1;
      while (stabilising !== 1'b0) @(posedge clk);
      rd(12'h024);
      check(r[7:0] < 8'h04, 1'b1);
      $display("low power test done");
      end_of_test;
   end
endmodule : core_prescale_rti_timer_bench
`default_nettype wire

// ---- bench/core_timer_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module core_timer_asserts #(
   parameter int unsigned STAB_CYCLES = 16
) (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cpu_irq_mask,
   input wire logic        wait_mode,
   input wire logic        irq_req,
   input wire logic        wait_exit,
   input wire logic        stabilising,
   input wire logic        guard_timeout
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   int unsigned stab_cnt;
   wire acc = psel && penable && !pready;
   wire wr  = psel && pwrite;
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst) stab_cnt <= 0;
      else stab_cnt <= stabilising ? stab_cnt + 1 : 0;
   chk_ready_once: assert property (acc |=> pready ##1 !pready)
      else $error("pready timing");
   chk_rd_upper: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("prdata upper bits");
   chk_count_wr_ok: assert property (acc && pwrite && paddr == 12'h024 |=> !pslverr)
      else $error("count write error");
   chk_irq_masked: assert property (cpu_irq_mask |=> !irq_req)
      else $error("irq while masked");
   // a flag or enable can only drop through a write, one cycle of lag
   chk_irq_holds: assert property (irq_req && !cpu_irq_mask && !wr && !$past(wr)
      |=> irq_req)
      else $error("irq dropped");
   chk_exit_irq: assert property (wait_exit |-> irq_req)
      else $error("wait exit without request");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_wait_exit: assert property (!wait_mode |=> !wait_exit)
      else $error("wait exit outside wait");
   chk_stab_bound: assert property (stabilising |-> stab_cnt <= STAB_CYCLES + 2)
      else $error("stabilise too long");
   chk_stab_len: assert property ($fell(stabilising) |-> $past(stab_cnt) >= STAB_CYCLES - 1)
      else $error("stabilise too short");
   chk_guard_pulse: assert property (guard_timeout |=> !guard_timeout)
      else $error("guard pulse too long");
endmodule : core_timer_asserts
bind core_prescale_rti_timer core_timer_asserts #(.STAB_CYCLES(STAB_CYCLES)) u_core_timer_asserts (
   .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cpu_irq_mask(cpu_irq_mask), .wait_mode(wait_mode), .irq_req(irq_req),
   .wait_exit(wait_exit), .stabilising(stabilising), .guard_timeout(guard_timeout));
`default_nettype wire

// ---- bench/host_cpu_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_cpu_model (
   input wire logic        clk,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic        wait_exit,
   output logic            psel,
   output logic            penable,
   output logic            pwrite,
   output logic [11:0]     paddr,
   output logic [31:0]     pwdata,
   output logic            wait_mode
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata, wait_mode} = '0;
   end
   // call just after a rising edge; one idle cycle follows each transfer
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
   task enter_wait;
      wait_mode <= 1'b1;
   endtask : enter_wait
   always @(posedge clk) if (wait_exit) wait_mode <= 1'b0;
endmodule : host_cpu_model
`default_nettype wire

// ---- hdl/chain_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface chain_if;
   import core_timer_pkg::*;

   logic       clear;
   tap_sel_t   tap_sel;
   logic       guard_service;
   logic [7:0] count;
   logic       ovf_evt;
   logic       per_evt;
   logic       guard_evt;

   modport ctl (
      output clear,
      output tap_sel,
      output guard_service,
      input  count,
      input  ovf_evt,
      input  per_evt,
      input  guard_evt
   );

   modport chain (
      input  clear,
      input  tap_sel,
      input  guard_service,
      output count,
      output ovf_evt,
      output per_evt,
      output guard_evt
   );
endinterface : chain_if

`default_nettype wire

// ---- hdl/core_prescale_chain.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "core_timer_regs.svh"

module core_prescale_chain
   import core_timer_pkg::*;
(
   input  wire logic clk,
   input  wire logic sys_rst,
   chain_if.chain    link
);

   logic [`CHAIN_WIDTH-1:0] chain_reg;
   logic [`GUARD_BITS-1:0]  guard_reg;
   logic                    per_hit;

   // true when the low n bits are all ones, so the next increment wraps them
   function automatic logic low_ones(input logic [`CHAIN_WIDTH-1:0] v, input int unsigned n);
      logic [`CHAIN_WIDTH-1:0] mask;
      mask = {`CHAIN_WIDTH{1'b1}} >> (`CHAIN_WIDTH - n);
      return &(v | ~mask);
   endfunction : low_ones

   // prescale by four then 8-bit counter then the periodic stages
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         chain_reg <= '0;
      end else if (link.clear) begin
         chain_reg <= '0;
      end else begin
         chain_reg <= chain_reg + `CHAIN_WIDTH'(1);
      end
   end

   assign link.count   = chain_reg[`PRESCALE_BITS +: `COUNT_BITS];
   assign link.ovf_evt = ~link.clear & low_ones(chain_reg, `OVF_STAGE_BITS);
   // tap 00..11 wraps 14..17 stages
   assign per_hit      = low_ones(chain_reg, `TAP_BASE_BITS + int'(link.tap_sel));
   assign link.per_evt = ~link.clear & per_hit;

   // final divide-by-eight stage; service clears only this stage
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         guard_reg <= '0;
      end else if (link.clear || link.guard_service) begin
         guard_reg <= '0;
      end else if (link.per_evt) begin
         guard_reg <= guard_reg + `GUARD_BITS'(1);
      end
   end

   assign link.guard_evt = link.per_evt & ~link.guard_service & (&guard_reg);

endmodule : core_prescale_chain

`default_nettype wire

// ---- hdl/core_prescale_rti_timer.sv ----
// Behaviour
// - overflow enable, overflow flag and clear CPU mask request an interrupt.
// - periodic enable, periodic flag and clear CPU mask request an interrupt.
// - two-bit tap select picks periodic source; reset value 11, slowest.
// - taps 00..11 divide bus clock by 2^14, 2^15, 2^16, 2^17.
// - counter register is read-only, shows 8-bit counter, resets to zero.
// - the 8-bit counter advances once every four bus clocks.
// - power-on clears chain, counts 2016 cycles, clears again, then runs.
// - external reset outside power-on clears the whole divider chain.
// - entering stop clears the counter chain.
// - stop exit waits 2016 cycles, then clears the timer and resumes.
// - in wait mode the timer keeps counting and setting flags.
// - an enabled timer interrupt during wait makes the processor leave it.
// - overflow flag sets on counter wrap; writing zero clears, one ignored.
// - periodic flag sets on selected tap; writing zero clears, one ignored.
// - overflow comes from the last counter stage, once per 1024 bus cycles.
// - writing zero to service bit 0 clears only the final divide-by-eight.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "core_timer_regs.svh"

module core_prescale_rti_timer
   import core_timer_pkg::*;
#(
   parameter int unsigned STAB_CYCLES = `STAB_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_reset_n,
   input  wire logic        cpu_irq_mask,
   input  wire logic        wait_mode,
   input  wire logic        stop_mode,
   input  wire logic        stop_wake,
   output logic             irq_req,
   output logic             wait_exit,
   output logic             stabilising,
   output logic             guard_timeout
);

   localparam int CNT_W = $clog2(STAB_CYCLES + 1);

   chain_if link ();

   core_prescale_chain u_chain (
      .clk     (clk),
      .sys_rst (sys_rst),
      .link    (link)
   );

   phase_t           phase_reg;
   logic [CNT_W-1:0] stab_cnt_reg;
   logic             clear_reg;
   logic [1:0]       ext_rst_sync_reg;
   logic             ext_rst_active;
   logic             ovf_flag_reg;
   logic             per_flag_reg;
   logic             ovf_en_reg;
   logic             per_en_reg;
   tap_sel_t         tap_reg;
   logic             access;
   logic             wr_commit;
   logic [7:0]       index;
   logic             flag_wr;
   logic             service_wr;
   logic             irq_cause;
   logic [31:0]      rd_word;

   // the pin is asynchronous; only the second stage is looked at
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_rst_sync_reg <= 2'h0;
      end else begin
         ext_rst_sync_reg <= {ext_rst_sync_reg[0], ~ext_reset_n};
      end
   end

   assign ext_rst_active = ext_rst_sync_reg[1];

   // low-power and start-up sequencing
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_reg    <= PH_POWER_ON;
         stab_cnt_reg <= '0;
      end else begin
         unique case (phase_reg)
            PH_POWER_ON: begin
               // chain keeps counting while the power-on delay runs
               if (stab_cnt_reg == CNT_W'(STAB_CYCLES - 1)) begin
                  phase_reg    <= PH_RUN;
                  stab_cnt_reg <= '0;
               end else begin
                  stab_cnt_reg <= stab_cnt_reg + CNT_W'(1);
               end
            end
            PH_RUN: begin
               // wait mode does not stop the chain
               if (stop_mode) begin
                  phase_reg <= PH_STOP;
               end
            end
            PH_STOP: begin
               // either wake source restarts the delay; the chain stays cleared meanwhile
               if (stop_wake || ext_rst_active) begin
                  phase_reg    <= PH_STABILISE;
                  stab_cnt_reg <= '0;
               end
            end
            PH_STABILISE: begin
               if (stab_cnt_reg == CNT_W'(STAB_CYCLES - 1)) begin
                  phase_reg    <= PH_RUN;
                  stab_cnt_reg <= '0;
               end else begin
                  stab_cnt_reg <= stab_cnt_reg + CNT_W'(1);
               end
            end
         endcase
      end
   end

   // registered clear: a one-cycle pulse at the end of the power-on delay, held in stop and through the stop-exit delay
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         clear_reg <= 1'b1;
      end else begin
         unique case (phase_reg)
            PH_POWER_ON: clear_reg <= (stab_cnt_reg == CNT_W'(STAB_CYCLES - 1));
            PH_RUN: clear_reg <= stop_mode | ext_rst_active;
            PH_STOP: clear_reg <= 1'b1;
            PH_STABILISE: clear_reg <= 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stabilising <= 1'b1;
      end else begin
         stabilising <= (phase_reg == PH_POWER_ON) || (phase_reg == PH_STABILISE);
      end
   end

   assign link.clear = clear_reg;
   assign link.tap_sel = tap_reg;

   // register index from a byte address; used by the decode and the map check
   function automatic logic [7:0] reg_index(input logic [11:0] a);
      return {2'h0, a[`ADDR_LSB +: 6]};
   endfunction : reg_index

   // apb: one wait state so read data and pready come from flip-flops
   assign access     = psel & penable;
   assign wr_commit  = access & pready & pwrite & ~pslverr;
   assign index      = reg_index(paddr);
   assign flag_wr    = wr_commit && (index == `CTL_STAT_INDEX);
   assign service_wr = wr_commit && (index == `SERVICE_INDEX) && !pwdata[`SERVICE_BIT];

   assign link.guard_service = service_wr;

   function automatic logic mapped(input logic [11:0] a);
      logic [7:0] i;
      i = reg_index(a);
      return (a[1:0] == 2'h0) && (a[11:8] == 4'h0) &&
             ((i == `CTL_STAT_INDEX) || (i == `COUNT_INDEX) || (i == `SERVICE_INDEX));
   endfunction : mapped

   // value of the addressed register; writes and unmapped reads give zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (!pwrite && mapped(paddr)) begin
         if (index == `CTL_STAT_INDEX) begin
            rd_word = {24'h00_0000, ovf_flag_reg, per_flag_reg, ovf_en_reg,
                       per_en_reg, 2'h0, tap_reg};
         end else if (index == `COUNT_INDEX) begin
            rd_word = {24'h00_0000, link.count};
         end
      end
   end

   // pready pulses in the second access cycle, so every transfer has one wait state
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
      end else begin
         pready <= access & ~pready;
      end
   end

   // the error travels with pready and is low otherwise
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pslverr <= 1'b0;
      end else if (access && !pready) begin
         pslverr <= !mapped(paddr) || (!pwrite && index == `SERVICE_INDEX);
      end else begin
         pslverr <= 1'b0;
      end
   end

   // read data is captured once per transfer and then held
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (access && !pready) begin
         prdata <= rd_word;
      end
   end

   // interrupt enables
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ovf_en_reg <= 1'b0;
         per_en_reg <= 1'b0;
      end else if (flag_wr) begin
         ovf_en_reg <= pwdata[`OVF_EN_BIT];
         per_en_reg <= pwdata[`PER_EN_BIT];
      end
   end

   // tap changes are not synchronised to the chain; software guards it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tap_reg <= `TAP_RESET;
      end else if (flag_wr) begin
         tap_reg <= pwdata[`TAP_HI_BIT:`TAP_LO_BIT];
      end
   end

   // sticky flags: a set in the same cycle as a clearing write wins
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ovf_flag_reg <= 1'b0;
      end else if (link.ovf_evt) begin
         ovf_flag_reg <= 1'b1;
      end else if (flag_wr && !pwdata[`OVF_FLAG_BIT]) begin
         ovf_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         per_flag_reg <= 1'b0;
      end else if (link.per_evt) begin
         per_flag_reg <= 1'b1;
      end else if (flag_wr && !pwdata[`PER_FLAG_BIT]) begin
         per_flag_reg <= 1'b0;
      end
   end

   // level request, held until the flag or enable is cleared or the mask set
   assign irq_cause = ~cpu_irq_mask &
                      ((ovf_en_reg & ovf_flag_reg) |
                       (per_en_reg & per_flag_reg));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= irq_cause;
      end
   end

   // a core in wait has no clock of its own, so the wake-up is a separate line
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_exit <= 1'b0;
      end else begin
         wait_exit <= irq_cause & wait_mode;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         guard_timeout <= 1'b0;
      end else begin
         guard_timeout <= link.guard_evt;
      end
   end

endmodule : core_prescale_rti_timer

`default_nettype wire

// ---- hdl/core_timer_pkg.sv ----
package core_timer_pkg;

   typedef enum logic [1:0] {
      PH_POWER_ON,
      PH_RUN,
      PH_STOP,
      PH_STABILISE
   } phase_t;

   typedef logic [1:0] tap_sel_t;

endpackage : core_timer_pkg

// ---- hdl/core_timer_regs.svh ----
`ifndef CORE_TIMER_REGS_SVH
`define CORE_TIMER_REGS_SVH

// register indices; the byte address is four times the index
`define CTL_STAT_INDEX       8'h08
`define COUNT_INDEX          8'h09
`define SERVICE_INDEX        8'h0A
`define ADDR_LSB             2

// fields of core_timer_ctl_stat, then the count reset value and the service bit
`define OVF_FLAG_BIT         7
`define PER_FLAG_BIT         6
`define OVF_EN_BIT           5
`define PER_EN_BIT           4
`define TAP_HI_BIT           1
`define TAP_LO_BIT           0
`define TAP_RESET            2'h3
`define COUNT_RESET          8'h00
`define SERVICE_BIT          0

// divider chain
`define CHAIN_WIDTH          17
`define PRESCALE_BITS        2
`define COUNT_BITS           8
`define OVF_STAGE_BITS       10
`define TAP_BASE_BITS        14
`define GUARD_BITS           3

// stabilisation after power-on or stop exit, in bus cycles
`define STAB_CYCLES          2016

`endif
